// ==== system_reset_controller_cfg.svh ====
// Register map, field positions, reset values and timing counts.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM word bus.
`ifndef SYSTEM_RESET_CONTROLLER_CFG_SVH
`define SYSTEM_RESET_CONTROLLER_CFG_SVH
// Byte offsets of the word registers.
`define OFS_CTRL 5'h00
`define OFS_WDT_TIMEOUT 5'h04
`define OFS_LVI_CFG 5'h08
`define OFS_BUZZ_CFG 5'h0c
`define OFS_STATUS 5'h10
`define OFS_IRQ_PEND 5'h14
// Control register fields.
`define CTRL_SW_RESET 0
`define CTRL_SW_BLOCK 1
`define CTRL_WDT_EN 2
`define CTRL_WDT_KICK 3
`define CTRL_AREG_EN 4
// Supervisor configuration fields.
`define LVI_A_CODE_LSB 0
`define LVI_D_CODE_LSB 4
`define LVI_A_RST_MODE 8
`define LVI_D_RST_MODE 9
`define LVI_A_EN 10
`define LVI_D_EN 11
`define LVI_H_EN 12
// Reset values.
`define RST_WDT_TIMEOUT 16'h1000
`define RST_BUZZ_PERIOD 16'h0100
`define RST_LVI_CFG 13'h0000
`define RST_SYNC 3'h1
// Supervisor levels in millivolts.
`define LVI_BASE_MV 13'h06a4
`define LVI_STEP_MV 13'h00fa
`define HVI_FIXED_MV 13'h1676
// Timing.
`define CLK_PERIOD_NS 100
`define POR_PULSE_NS 150
`define POR_PULSE_CYC ((`POR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_REARM_NS 10000
`define EXT_REARM_CYC ((`EXT_REARM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUZZ_ON_CYC 16'h0004
`endif

// ==== system_reset_controller_pkg.sv ====
// Types shared by the reset controller.
// Assumes the constants of system_reset_controller_cfg.svh.
package system_reset_controller_pkg;
    typedef logic [12:0] mv_t;
    typedef logic [3:0] trip_code_t;
    typedef logic [15:0] count_t;
    typedef logic [1:0] pulse_cnt_t;
    typedef logic [7:0] cause_t;
    typedef logic [2:0] irq_vec_t;
endpackage : system_reset_controller_pkg

// ==== system_reset_controller.sv ====
// Reset controller: merges all reset sources into one system reset.
// Assumes supply readings arrive in millivolts on i_clk, power mode flags
// come from the power manager on i_clk, and trip flags and the reset pin are asynchronous.
// How it works
// - Reset held as long as the external reset pin stays low.
// - External reset pin stays active during sleep and hibernate.
// - Writing the software reset bit gives a full system reset.
// - Processor and DMA writes reach the software reset bit alike.
// - A block bit stops the software reset bit from acting.
// - Enabled watchdog resets the system when not kicked in time.
// - Power-on reset leaves the watchdog disabled.
// - Watchdog enable cannot be cleared except by power-on reset.
// - Status keeps reset causes and supervisor events until power-on reset.
// - Power-on reset pulse lasts at least 150 ns.
// - After boot the power-on monitor stops and precise monitor takes over.
// - Precise monitor trip gives a system reset; unlike power-on, it keeps watchdog enable and status.
// - Software has no way to disable the digital precise monitor.
// - Disabling the analog regulator disables the analog precise monitor.
// - Precise monitor off in low power except during sleep buzz.
// - Each low-voltage supervisor can reset instead of interrupting.
// - Low-voltage trip levels run 1.70 V to 5.45 V in 250 mV steps.
// - High-voltage supervisor trips above fixed 5.75 V.
// - Supervisors stay off until power-on reset has finished.
// - Interrupt during buzz first wakes the device, then is presented.
// - System reset returns the block registers to reset state, except watchdog enable and status.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "system_reset_controller_cfg.svh"

module system_reset_controller (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_external_reset_n,
    input wire logic i_prec_dig_trip,
    input wire logic i_prec_ana_trip,
    input wire logic [12:0] i_vdda_mv,
    input wire logic [12:0] i_vddd_mv,
    input wire logic i_sleep,
    input wire logic i_hibernate,
    output logic o_sys_reset,
    output logic o_por_monitor_en,
    output logic o_prec_dig_en,
    output logic o_prec_ana_en,
    output logic o_areg_en,
    output logic o_buzz,
    output logic o_wake_req,
    output logic o_analog_low_voltage_irq,
    output logic o_digital_low_voltage_irq,
    output logic o_analog_high_voltage_irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic sw_block_q;
    logic wdt_en_q;
    logic areg_en_q;
    system_reset_controller_pkg::count_t wdt_timeout_q;
    system_reset_controller_pkg::count_t wdt_cnt_q;
    system_reset_controller_pkg::count_t wdt_cnt_d;
    system_reset_controller_pkg::count_t buzz_period_q;
    system_reset_controller_pkg::count_t buzz_cnt_q;
    system_reset_controller_pkg::count_t buzz_cnt_d;
    logic [12:0] lvi_cfg_q;
    system_reset_controller_pkg::cause_t status_q;
    system_reset_controller_pkg::irq_vec_t pend_q;
    system_reset_controller_pkg::irq_vec_t pend_d;
    system_reset_controller_pkg::pulse_cnt_t rst_cnt_q;
    system_reset_controller_pkg::pulse_cnt_t rst_cnt_d;
    logic boot_q;
    logic blk_rst;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pin and trip flags cross in through two flops each; only the
    // second stage is ever looked at.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1_q <= `RST_SYNC;
            sync2_q <= `RST_SYNC;
        end else begin
            sync1_q <= {i_prec_ana_trip, i_prec_dig_trip, i_external_reset_n};
            sync2_q <= sync1_q;
        end
    end

    wire ext_low = ~sync2_q[0];
    wire prec_dig_s = sync2_q[1];
    wire prec_ana_s = sync2_q[2];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One wait state per access; the write lands and the read data
    // stand on the edge where waitrequest is low.
    wire bus_req = i_avs_read | i_avs_write;
    wire wr_en = i_avs_write & ack_q;
    wire hit_ctrl = (i_avs_address == `OFS_CTRL);
    wire hit_wdt = (i_avs_address == `OFS_WDT_TIMEOUT);
    wire hit_lvi = (i_avs_address == `OFS_LVI_CFG);
    wire hit_buzz = (i_avs_address == `OFS_BUZZ_CFG);
    wire hit_stat = (i_avs_address == `OFS_STATUS);
    wire hit_pend = (i_avs_address == `OFS_IRQ_PEND);
    wire wr_ctrl = wr_en & hit_ctrl;
    wire wr_pend = wr_en & hit_pend;

    // DMA and processor share this port, so both reach the bit.
    wire sw_req = wr_ctrl & i_avs_writedata[`CTRL_SW_RESET];
    wire sw_fire = sw_req & ~sw_block_q;
    wire kick = wr_ctrl & i_avs_writedata[`CTRL_WDT_KICK];

    assign o_avs_waitrequest = bus_req & ~ack_q;

    // Read selection; unmapped offsets read as zero.
    wire [31:0] rd_ctrl = {27'h0000000, areg_en_q, 1'b0, wdt_en_q, sw_block_q, 1'b0};
    wire [31:0] rd_wdt = {16'h0000, wdt_timeout_q};
    wire [31:0] rd_lvi = {19'h00000, lvi_cfg_q};
    wire [31:0] rd_buzz = {16'h0000, buzz_period_q};
    wire [31:0] rd_stat = {24'h000000, status_q};
    wire [31:0] rd_pend = {29'h00000000, pend_q};
    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                         hit_wdt ? rd_wdt :
                         hit_lvi ? rd_lvi :
                         hit_buzz ? rd_buzz :
                         hit_stat ? rd_stat :
                         hit_pend ? rd_pend : 32'h00000000;

    // Handshake and read data; only power-on reset touches these so
    // an access in flight is still answered through a system reset.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (i_avs_read & ~ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign o_avs_readdata = rdata_q;

    // ------------------------------------------------------------
    // Power modes and buzz timing
    // ------------------------------------------------------------
    wire low_power = i_sleep | i_hibernate;
    wire sleep_only = i_sleep & ~i_hibernate;
    wire buzz = sleep_only & (buzz_cnt_q < `BUZZ_ON_CYC);
    wire awake = ~low_power;
    wire reg_on = awake | buzz;
    // Supervision begins only once boot has ended.
    wire mon_on = boot_q & reg_on;
    wire buzz_wrap = (buzz_cnt_q >= buzz_period_q);

    assign buzz_cnt_d = (~sleep_only | buzz_wrap) ? 16'h0000 : buzz_cnt_q + 16'h0001;
    assign o_buzz = buzz;

    // Buzz counter runs only in sleep; hibernate gets no buzz.
    always_ff @(posedge i_clk) begin
        if (blk_rst) begin
            buzz_cnt_q <= 16'h0000;
        end else begin
            buzz_cnt_q <= buzz_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Precise low-voltage monitor
    // ------------------------------------------------------------
    // The power-on monitor is live only until boot ends.
    assign o_por_monitor_en = ~boot_q;
    // No register bit reaches the digital enable.
    assign o_prec_dig_en = mon_on;
    // Analog half follows the analog regulator.
    assign o_prec_ana_en = mon_on & areg_en_q;
    // Regulators and monitor drop in low power save for buzz windows.
    assign o_areg_en = areg_en_q & reg_on;

    wire prec_trip = (prec_dig_s & o_prec_dig_en) | (prec_ana_s & o_prec_ana_en);

    // ------------------------------------------------------------
    // Voltage supervisors
    // ------------------------------------------------------------
    wire [3:0] a_code = lvi_cfg_q[`LVI_A_CODE_LSB+:4];
    wire [3:0] d_code = lvi_cfg_q[`LVI_D_CODE_LSB+:4];
    // Sixteen codes step from the base by a fixed millivolt step.
    wire [12:0] a_level = `LVI_BASE_MV + 13'(`LVI_STEP_MV * {9'h000, a_code});
    wire [12:0] d_level = `LVI_BASE_MV + 13'(`LVI_STEP_MV * {9'h000, d_code});
    wire a_trip = mon_on & lvi_cfg_q[`LVI_A_EN] & (i_vdda_mv < a_level);
    wire d_trip = mon_on & lvi_cfg_q[`LVI_D_EN] & (i_vddd_mv < d_level);
    // The high threshold is a constant with no register behind it.
    wire h_trip = mon_on & lvi_cfg_q[`LVI_H_EN] & (i_vdda_mv > `HVI_FIXED_MV);
    // Each low supervisor picks reset or interrupt.
    wire a_rst = a_trip & lvi_cfg_q[`LVI_A_RST_MODE];
    wire d_rst = d_trip & lvi_cfg_q[`LVI_D_RST_MODE];
    wire [2:0] irq_evt = {h_trip, d_trip & ~d_rst, a_trip & ~a_rst};

    // Pending events; a new event beats a clear in the same cycle.
    assign pend_d = (pend_q & ~(wr_pend ? i_avs_writedata[2:0] : 3'h0)) | irq_evt;

    always_ff @(posedge i_clk) begin
        if (blk_rst) begin
            pend_q <= 3'h0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Asleep, a pending event asks for wake-up and is shown only once
    // the power manager has brought the device back to active.
    assign o_wake_req = (|pend_q) & low_power;
    assign o_analog_low_voltage_irq = pend_q[0] & awake;
    assign o_digital_low_voltage_irq = pend_q[1] & awake;
    assign o_analog_high_voltage_irq = pend_q[2] & awake;

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    wire wdt_fire = wdt_en_q & (wdt_cnt_q >= wdt_timeout_q);

    assign wdt_cnt_d = (~wdt_en_q | kick) ? 16'h0000 : wdt_cnt_q + 16'h0001;

    always_ff @(posedge i_clk) begin
        if (blk_rst) begin
            wdt_cnt_q <= 16'h0000;
        end else begin
            wdt_cnt_q <= wdt_cnt_d;
        end
    end

    // Enable is set-only and survives every reset but power-on.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wdt_en_q <= 1'b0;
        end else if (wr_ctrl & i_avs_writedata[`CTRL_WDT_EN]) begin
            wdt_en_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Reloaded with reset values by every system reset, not only at power-on.
    always_ff @(posedge i_clk) begin
        if (blk_rst) begin
            sw_block_q <= 1'b0;
            areg_en_q <= 1'b1;
            wdt_timeout_q <= `RST_WDT_TIMEOUT;
            buzz_period_q <= `RST_BUZZ_PERIOD;
            lvi_cfg_q <= `RST_LVI_CFG;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                sw_block_q <= i_avs_writedata[`CTRL_SW_BLOCK];
                areg_en_q <= i_avs_writedata[`CTRL_AREG_EN];
            end
            if (hit_wdt) begin
                wdt_timeout_q <= i_avs_writedata[15:0];
            end
            if (hit_buzz) begin
                buzz_period_q <= i_avs_writedata[15:0];
            end
            if (hit_lvi) begin
                lvi_cfg_q <= i_avs_writedata[12:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Reset merge and stretch
    // ------------------------------------------------------------
    // The pin is not gated by any power mode, so it acts in sleep
    // and hibernate; a low level keeps reloading the stretch.
    wire ext_req = ext_low;
    wire any_src = ext_req | prec_trip | sw_fire | wdt_fire | a_rst | d_rst;
    wire [7:0] causes = {a_rst | d_rst, irq_evt, wdt_fire, sw_fire, prec_trip, ext_req};

    // Every source loads the same count as power-on, so all give the
    // same pulse; the power-on pulse is its reset time plus that count.
    assign rst_cnt_d = any_src ? 2'(`POR_PULSE_CYC) :
                       (rst_cnt_q != 2'h0) ? rst_cnt_q - 2'h1 : 2'h0;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rst_cnt_q <= 2'(`POR_PULSE_CYC);
        end else begin
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // Release waits for the stretch count, so it is always on a clock
    // edge; power-on asserts at once without waiting for the count.
    assign blk_rst = i_srst | (rst_cnt_q != 2'h0);
    assign o_sys_reset = blk_rst;

    // Boot is taken as done at the first release after power-on.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            boot_q <= 1'b0;
        end else if (rst_cnt_q == 2'h0) begin
            boot_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    // Sticky causes; only power-on clears them so firmware can read
    // why the last system reset happened.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            status_q <= 8'h00;
        end else begin
            status_q <= status_q | causes;
        end
    end

endmodule : system_reset_controller

// ==== system_reset_controller_monitor.sv ====
// Concurrent checks on the ports of the reset controller.
// Assumes the single i_clk domain; bound to every system_reset_controller instance.
`timescale 1ns/100ps

module system_reset_controller_monitor (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic o_avs_waitrequest,
    input wire logic i_external_reset_n,
    input wire logic i_sleep,
    input wire logic i_hibernate,
    input wire logic o_sys_reset,
    input wire logic o_por_monitor_en,
    input wire logic o_prec_dig_en,
    input wire logic o_prec_ana_en,
    input wire logic o_areg_en,
    input wire logic o_buzz,
    input wire logic o_wake_req,
    input wire logic o_analog_low_voltage_irq,
    input wire logic o_digital_low_voltage_irq,
    input wire logic o_analog_high_voltage_irq
);
    // ----------------------------------------
    // Block bit shadow and properties
    // ----------------------------------------
    logic blk_q;
    logic blk_d;
    logic sw_hit;
    logic asleep;
    logic any_irq;
    // The shadow drops with any system reset, since the real bit is cleared by it too.
    assign sw_hit = i_avs_write && !o_avs_waitrequest && (i_avs_address == 5'h00);
    assign blk_d = o_sys_reset ? 1'b0 : (sw_hit ? i_avs_writedata[1] : blk_q);
    assign asleep = i_sleep || i_hibernate;
    assign any_irq = o_analog_low_voltage_irq || o_digital_low_voltage_irq || o_analog_high_voltage_irq;
    // Shadow register of the software reset block bit.
    always_ff @(posedge i_clk) begin
        blk_q <= blk_d;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_pin_holds_reset: assert property (!i_external_reset_n [*4] |=> o_sys_reset)
        else $error("reset pin held low without system reset");
    a_sw_reset_acts: assert property (sw_hit && i_avs_writedata[0] && !i_avs_writedata[1] && !blk_q
        && !o_sys_reset |-> ##[1:2] o_sys_reset) else $error("software reset write ignored");
    a_reset_min_width: assert property ($rose(o_sys_reset) |=> o_sys_reset)
        else $error("system reset pulse too short");
    a_prec_dig_awake: assert property (!o_por_monitor_en && !asleep |-> o_prec_dig_en)
        else $error("digital precise monitor off while awake");
    a_prec_ana_areg: assert property (o_prec_ana_en == (o_prec_dig_en && o_areg_en))
        else $error("analog precise monitor not tied to regulator");
    a_prec_off_sleep: assert property (asleep && !o_buzz |-> !o_prec_dig_en && !o_areg_en)
        else $error("precise monitor on in low power outside buzz");
    a_buzz_sleep_only: assert property (o_buzz |-> i_sleep && !i_hibernate)
        else $error("buzz outside sleep");
    a_sup_after_boot: assert property (o_por_monitor_en |-> !any_irq)
        else $error("supervisor interrupt before boot done");
    a_irq_awake_only: assert property (asleep |-> !any_irq)
        else $error("interrupt presented before wakeup");
    a_wake_when_asleep: assert property (o_wake_req |-> asleep)
        else $error("wake request while awake");
    a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer later than one wait state");
    c_sw_reset: cover property (sw_hit && i_avs_writedata[0] && !blk_q);
    c_wake: cover property ($rose(o_wake_req));
    c_pin_hib: cover property (!i_external_reset_n && i_hibernate);
endmodule : system_reset_controller_monitor

bind system_reset_controller system_reset_controller_monitor u_monitor (.i_clk(i_clk), .i_srst(i_srst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_external_reset_n(i_external_reset_n), .i_sleep(i_sleep), .i_hibernate(i_hibernate),
    .o_sys_reset(o_sys_reset), .o_por_monitor_en(o_por_monitor_en), .o_prec_dig_en(o_prec_dig_en),
    .o_prec_ana_en(o_prec_ana_en), .o_areg_en(o_areg_en), .o_buzz(o_buzz), .o_wake_req(o_wake_req),
    .o_analog_low_voltage_irq(o_analog_low_voltage_irq), .o_digital_low_voltage_irq(o_digital_low_voltage_irq),
    .o_analog_high_voltage_irq(o_analog_high_voltage_irq));

// ==== ext_reset_driver.sv ====
// Board-side driver of the active-low reset pin.
// Assumes the pin has a pull-up, so a released pin reads high.
`timescale 1ns/100ps
`include "system_reset_controller_cfg.svh"

module ext_reset_driver (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_len,
    output logic o_pin_n,
    output logic o_busy
);
    // ----------------------------------------
    // Pulse and re-arm gap
    // ----------------------------------------
    logic [7:0] low_q = 8'h00;
    logic [7:0] gap_q = 8'h00;
    // A request during the re-arm gap is ignored, so the pin never drops again too early.
    always @(posedge i_clk) begin
        if (low_q != 8'h00) begin
            low_q <= low_q - 8'h01;
            if (low_q == 8'h01) gap_q <= 8'(`EXT_REARM_CYC);
        end else if (gap_q != 8'h00) begin
            gap_q <= gap_q - 8'h01;
        end else if (i_go) begin
            low_q <= i_len;
        end
    end
    assign o_pin_n = (low_q == 8'h00);
    assign o_busy = (low_q != 8'h00) || (gap_q != 8'h00);
endmodule : ext_reset_driver

// ==== testbench.sv ====
// Self-checking bench for the reset controller.
// Assumes the design files, the cfg header and the pin driver model are compiled first.
`timescale 1ns/100ps
`include "system_reset_controller_cfg.svh"

module testbench;
    // ----------------------------------------
    // Stimulus, bus tasks and scenarios
    // ----------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rd_en = 1'b0, wr_en = 1'b0, sleep = 1'b0, hib = 1'b0, ext_go = 1'b0, trip_d = 1'b0, trip_a = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [12:0] vdda = 13'h157c, vddd = 13'h157c;
    logic ext_n, ext_busy, sys_rst, waitreq, wake, irq_a, irq_d, irq_h;
    logic [2:0] iv;
    logic [4:0] ofs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
    logic [31:0] rv [7] = '{32'h10, 32'h1000, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0};
    int errors = 0, checks = 0, rst_cnt = 0, n, c;

    // Free-running 10 MHz clock.
    always #50 clk = ~clk;
    // Counts cycles of system reset, so a reset that should not happen is seen.
    always @(negedge clk) if (sys_rst === 1'b1) rst_cnt++;

    system_reset_controller u_dut (.i_clk(clk), .i_srst(srst), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_external_reset_n(ext_n), .i_prec_dig_trip(trip_d), .i_prec_ana_trip(trip_a), .i_vdda_mv(vdda),
        .i_vddd_mv(vddd), .i_sleep(sleep), .i_hibernate(hib), .o_sys_reset(sys_rst), .o_por_monitor_en(),
        .o_prec_dig_en(), .o_prec_ana_en(), .o_areg_en(), .o_buzz(), .o_wake_req(wake),
        .o_analog_low_voltage_irq(irq_a), .o_digital_low_voltage_irq(irq_d), .o_analog_high_voltage_irq(irq_h));
    ext_reset_driver u_ext (.i_clk(clk), .i_go(ext_go), .i_len(8'h08), .o_pin_n(ext_n), .o_busy(ext_busy));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One Avalon access; waitrequest and read data are taken at the same rising edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        rd_en <= !wr;
        wr_en <= wr;
        addr <= a;
        wdata <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : bus

    task automatic wait_rst(input int lim);
        n = 0;
        while (sys_rst !== 1'b1 && n < lim) begin @(negedge clk); n++; end
        @(posedge clk);
    endtask : wait_rst

    task automatic settle;
        while (sys_rst !== 1'b0) @(negedge clk);
        @(posedge clk);
    endtask : settle

    task automatic sample;
        repeat (4) @(posedge clk);
        @(negedge clk);
        iv = {irq_h, irq_d, irq_a};
        @(posedge clk);
    endtask : sample

    // Trip level of a low supervisor code, in millivolts.
    function automatic logic [12:0] lvl(input int code);
        return 13'(1700 + 250 * code);
    endfunction : lvl

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial begin
        void'($urandom(25688));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        settle;
        for (int i = 0; i < 7; i++) begin bus(0, ofs[i], 0); check("reset value", rd, rv[i]); end
        c = $urandom();
        bus(1, `OFS_WDT_TIMEOUT, {16'h0, c[15:0]});
        bus(0, `OFS_WDT_TIMEOUT, 0);
        check("timeout rw", rd, {16'h0, c[15:0]});
        bus(1, `OFS_CTRL, 32'h12);
        c = rst_cnt;
        bus(1, `OFS_CTRL, 32'h13);
        repeat (6) @(posedge clk);
        check("blocked sw reset", rst_cnt - c, 0);
        bus(1, `OFS_CTRL, 32'h10);
        bus(1, `OFS_CTRL, 32'h11);
        wait_rst(20);
        check("sw reset", sys_rst, 1);
        settle;
        bus(0, `OFS_WDT_TIMEOUT, 0);
        check("timeout after reset", rd, 32'h1000);
        for (int k = 0; k < 2; k++) begin
            hib <= k[0];
            repeat (120) @(posedge clk);
            ext_go <= 1'b1;
            @(posedge clk);
            ext_go <= 1'b0;
            wait_rst(20);
            check("pin reset", sys_rst, 1);
            hib <= 1'b0;
            settle;
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) trip_d <= 1'b1; else trip_a <= 1'b1;
            wait_rst(20);
            check("precise trip", sys_rst, 1);
            trip_d <= 1'b0;
            trip_a <= 1'b0;
            settle;
        end
        bus(0, `OFS_STATUS, 0);
        check("status pin sw precise", rd[2:0], 3'b111);
        for (int k = 0; k < 2; k++) begin
            c = $urandom_range(15, 0);
            bus(1, `OFS_LVI_CFG, (32'h400 << k) | (c << (4 * k)));
            if (k == 0) vdda <= lvl(c); else vddd <= lvl(c);
            sample;
            check("at trip level", iv[k], 0);
            if (k == 0) vdda <= lvl(c) - 13'h1; else vddd <= lvl(c) - 13'h1;
            sample;
            check("below trip level", iv[k], 1);
            vdda <= 13'h157c;
            vddd <= 13'h157c;
            bus(1, `OFS_IRQ_PEND, 32'h1 << k);
            sample;
            check("irq cleared", iv[k], 0);
        end
        bus(1, `OFS_LVI_CFG, 32'h1000);
        vdda <= `HVI_FIXED_MV;
        sample;
        check("high at threshold", iv[2], 0);
        vdda <= `HVI_FIXED_MV + 13'h1;
        sample;
        check("high above threshold", iv[2], 1);
        vdda <= 13'h157c;
        bus(1, `OFS_IRQ_PEND, 32'h4);
        bus(0, `OFS_STATUS, 0);
        check("status irq events", rd[6:4], 3'b111);
        bus(1, `OFS_LVI_CFG, 32'h40f);
        sleep <= 1'b1;
        vdda <= 13'h1388;
        n = 0;
        while (wake !== 1'b1 && n < 600) begin @(negedge clk); n++; end
        check("wake in sleep", wake, 1);
        check("no irq asleep", irq_a, 0);
        @(posedge clk);
        sleep <= 1'b0;
        vdda <= 13'h157c;
        sample;
        check("irq after wake", iv[0], 1);
        bus(1, `OFS_IRQ_PEND, 32'h1);
        bus(1, `OFS_LVI_CFG, 32'h50f);
        vdda <= 13'h1388;
        wait_rst(20);
        check("low voltage reset", sys_rst, 1);
        vdda <= 13'h157c;
        settle;
        bus(0, `OFS_STATUS, 0);
        check("status lv reset", rd[7], 1);
        bus(1, `OFS_CTRL, 32'h0);
        c = rst_cnt;
        trip_a <= 1'b1;
        repeat (8) @(posedge clk);
        trip_a <= 1'b0;
        check("regulator off trip", rst_cnt - c, 0);
        bus(1, `OFS_WDT_TIMEOUT, 32'h20);
        bus(1, `OFS_CTRL, 32'h14);
        c = rst_cnt;
        repeat (4) begin repeat (12) @(posedge clk); bus(1, `OFS_CTRL, 32'h18); end
        check("kicked watchdog", rst_cnt - c, 0);
        bus(0, `OFS_CTRL, 0);
        check("enable sticks", rd[2], 1);
        wait_rst(100);
        check("watchdog fired", n > 16 && n < 40, 1);
        settle;
        bus(0, `OFS_STATUS, 0);
        check("status watchdog", rd[3], 1);
        bus(0, `OFS_CTRL, 0);
        check("enable survives", rd[2], 1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        settle;
        bus(0, `OFS_CTRL, 0);
        check("por ctrl", rd, 32'h10);
        bus(0, `OFS_STATUS, 0);
        check("por status", rd, 32'h0);
        tally_and_finish;
    end

    // Cuts a hang short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish;
    end
endmodule : testbench
